// >>> hdl/tmrcc_map.vh
// Register map, field positions and codes of the timer control block.
// Overview of operation
// - Grouping 01 pairs latches 1+2, 3+4, 5+6.
// - Grouping 10 groups latches 1+2+3 and 4+5+6.
// - Length field sets the continuous-mode maximum count: 16/12/10 bits.
// - Source field picks external, auxiliary or submain clock.
// - Input divider divides selected clock by 1/2/4/8.
// - Mode: stop, up to latch0, continuous, up/down.
// - Clear bit resets count, divider, direction; reads zero.
// - Rollover enable gates the rollover flag request.
// - Count register holds current count, software readable.
// - Buffer writes transfer into the channel compare latch.
// - Comparison uses compare latch, never the buffer.
// - Capture copies current count into the buffer.
// - Load-select bits choose when latches load.
`ifndef TMRCC_MAP_VH
`define TMRCC_MAP_VH
`define TMRCC_ADDR_W 12
`define TMRCC_OFF_CTL 12'h000
`define TMRCC_OFF_COUNT 12'h004
`define TMRCC_OFF_STATUS 12'h008
`define TMRCC_OFF_MASK 12'h00c
`define TMRCC_OFF_CHMODE 12'h010
`define TMRCC_OFF_LOADSEL 12'h014
`define TMRCC_OFF_BUF0 12'h020
`define TMRCC_OFF_BUF6 12'h038
`define TMRCC_NCH 7
`define TMRCC_CTL_RST 16'h0000
`define TMRCC_CTL_WMASK 16'hfffb
`define TMRCC_GRP_HI 14
`define TMRCC_GRP_LO 13
`define TMRCC_LEN_HI 12
`define TMRCC_LEN_LO 11
`define TMRCC_SRC_HI 9
`define TMRCC_SRC_LO 8
`define TMRCC_DIV_HI 7
`define TMRCC_DIV_LO 6
`define TMRCC_MODE_HI 5
`define TMRCC_MODE_LO 4
`define TMRCC_CLR_BIT 2
`define TMRCC_IE_BIT 1
`define TMRCC_IFG_BIT 0
`define TMRCC_GRP_NONE 2'h0
`define TMRCC_GRP_PAIR 2'h1
`define TMRCC_GRP_TRIO 2'h2
`define TMRCC_LEN_16 2'h0
`define TMRCC_LEN_12 2'h1
`define TMRCC_LEN_10 2'h2
`define TMRCC_MAX_16 16'hffff
`define TMRCC_MAX_12 16'h0fff
`define TMRCC_MAX_10 16'h03ff
`define TMRCC_SRC_EXT 2'h0
`define TMRCC_SRC_AUX 2'h1
`define TMRCC_SRC_SUB 2'h2
`define TMRCC_MODE_STOP 2'h0
`define TMRCC_MODE_UP 2'h1
`define TMRCC_MODE_CONT 2'h2
`define TMRCC_MODE_UPDN 2'h3
`define TMRCC_LD_WRITE 2'h0
`define TMRCC_LD_ZERO 2'h1
`define TMRCC_LD_ZERO_L0 2'h2
`define TMRCC_LD_L0 2'h3
`endif

// >>> hdl/tmrcc_prescale.v
// Clock source selection, pin synchronisers and input divider.
`timescale 1ns/10ps
`default_nettype none
`include "tmrcc_map.vh"
module tmrcc_prescale (
  input wire clk,
  input wire sys_rst,
  input wire external_timer_clock,
  input wire aux_clock,
  input wire submain_clock,
  input wire [1:0] clock_source_sel,
  input wire [1:0] input_divider_sel,
  input wire counter_clear,
  output reg tick
);
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [2:0] sync3;
  reg [2:0] div_cnt;
  reg src_edge;
  reg [2:0] div_last;
  // ****************************************
  // Synchronise the three clock pins.
  // ****************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end
    else
    begin
      sync1 <= {submain_clock, aux_clock, external_timer_clock};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  // ****************************************
  // Pick the source edge and the divide ratio.
  // ****************************************
  always @*
  begin
    case (clock_source_sel)
      `TMRCC_SRC_EXT: src_edge = sync2[0] & ~sync3[0];
      `TMRCC_SRC_AUX: src_edge = sync2[1] & ~sync3[1];
      `TMRCC_SRC_SUB: src_edge = sync2[2] & ~sync3[2];
      default: src_edge = 1'b0;
    endcase
    case (input_divider_sel)
      2'h0: div_last = 3'h0;
      2'h1: div_last = 3'h1;
      2'h2: div_last = 3'h3;
      default: div_last = 3'h7;
    endcase
  end
  // ****************************************
  // Divider issuing one tick per divided edge.
  // ****************************************
  always @(posedge clk)
  begin
    if (sys_rst || counter_clear)
    begin
      div_cnt <= 3'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (src_edge)
      begin
        if (div_cnt >= div_last)
        begin
          div_cnt <= 3'h0;
          tick <= 1'b1;
        end
        else
        begin
          div_cnt <= div_cnt + 3'h1;
        end
      end
    end
  end
endmodule // tmrcc_prescale
`default_nettype wire

// >>> hdl/tmrcc_top.v
// Timer control, count and capture/compare buffer block with APB access.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tmrcc_map.vh"
module tmrcc_top (
  input wire clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire external_timer_clock,
  input wire aux_clock,
  input wire submain_clock,
  input wire [6:0] capture_in,
  output reg [6:0] compare_match,
  output reg irq_out
);
  reg [15:0] timer_control;
  reg [15:0] timer_count;
  reg count_down;
  reg [7:0] irq_status;
  reg [7:0] irq_mask;
  reg [6:0] capture_mode;
  reg [13:0] latch_load_sel;
  reg [15:0] capture_compare_buffer [0:6];
  reg [15:0] compare_latch [0:6];
  reg [6:0] cap_s1;
  reg [6:0] cap_s2;
  reg [6:0] cap_s3;
  reg [15:0] next_count;
  reg next_down;
  reg rollover;
  reg [31:0] next_rdata;
  reg next_err;
  reg [6:0] ch_event;
  reg [6:0] load_now;
  reg [6:0] buf_wr;
  wire tick;
  wire counter_clear;
  wire wr_access;
  wire rd_setup;
  wire [1:0] grp;
  wire [1:0] mode;
  wire [15:0] len_max;
  wire zero_evt;
  wire l0_evt;
  wire [6:0] cap_rise;
  integer i, j, k;
  // ****************************************
  // Helper functions.
  // ****************************************
  function [15:0] max_of_len;
    input [1:0] len;
    begin
      case (len)
        `TMRCC_LEN_12: max_of_len = `TMRCC_MAX_12;
        `TMRCC_LEN_10: max_of_len = `TMRCC_MAX_10;
        default: max_of_len = `TMRCC_MAX_16;
      endcase
    end
  endfunction
  function [2:0] leader_of;
    input [2:0] ch;
    input [1:0] g;
    begin
      leader_of = ch;
      if (g == `TMRCC_GRP_PAIR && ch != 3'h0)
        leader_of = {ch[2:1], 1'b1} - {2'h0, ~ch[0]} - {2'h0, ~ch[0]};
      else if (g == `TMRCC_GRP_TRIO && ch != 3'h0)
        leader_of = (ch <= 3'h3) ? 3'h1 : 3'h4;
    end
  endfunction
  function load_fires;
    input [1:0] code;
    input own_wr;
    input z;
    input l0;
    input updn;
    begin
      case (code)
        `TMRCC_LD_WRITE: load_fires = own_wr;
        `TMRCC_LD_ZERO: load_fires = z;
        `TMRCC_LD_ZERO_L0: load_fires = z | (updn & l0);
        default: load_fires = l0;
      endcase
    end
  endfunction
  // ****************************************
  // Clock source and divider.
  // ****************************************
  tmrcc_prescale u_prescale (
    .clk(clk),
    .sys_rst(sys_rst),
    .external_timer_clock(external_timer_clock),
    .aux_clock(aux_clock),
    .submain_clock(submain_clock),
    .clock_source_sel(timer_control[`TMRCC_SRC_HI:`TMRCC_SRC_LO]),
    .input_divider_sel(timer_control[`TMRCC_DIV_HI:`TMRCC_DIV_LO]),
    .counter_clear(counter_clear),
    .tick(tick)
  );
  // ****************************************
  // Bus decode.
  // ****************************************
  assign wr_access = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;
  assign counter_clear = wr_access && paddr == `TMRCC_OFF_CTL &&
    pwdata[`TMRCC_CLR_BIT];
  assign grp = timer_control[`TMRCC_GRP_HI:`TMRCC_GRP_LO];
  assign mode = timer_control[`TMRCC_MODE_HI:`TMRCC_MODE_LO];
  assign len_max = max_of_len(timer_control[`TMRCC_LEN_HI:`TMRCC_LEN_LO]);
  assign cap_rise = cap_s2 & ~cap_s3;
  assign zero_evt = tick && mode != `TMRCC_MODE_STOP &&
    next_count == 16'h0000 && timer_count != 16'h0000;
  assign l0_evt = tick && mode == `TMRCC_MODE_UPDN &&
    next_count == compare_latch[0];
  always @*
  begin
    for (j = 0; j < `TMRCC_NCH; j = j + 1)
      buf_wr[j] = wr_access && paddr == `TMRCC_OFF_BUF0 + 12'h004 * j[11:0];
  end
  // ****************************************
  // Counter next state.
  // ****************************************
  always @*
  begin
    next_count = timer_count;
    next_down = count_down;
    rollover = 1'b0;
    if (counter_clear)
    begin
      next_count = 16'h0000;
      next_down = 1'b0;
    end
    else if (wr_access && paddr == `TMRCC_OFF_COUNT)
      next_count = pwdata[15:0];
    else if (tick)
    begin
      case (mode)
        `TMRCC_MODE_UP:
        begin
          if (timer_count >= compare_latch[0])
          begin
            next_count = 16'h0000;
            rollover = 1'b1;
          end
          else
            next_count = timer_count + 16'h0001;
        end
        `TMRCC_MODE_CONT:
        begin
          if (timer_count >= len_max)
          begin
            next_count = 16'h0000;
            rollover = 1'b1;
          end
          else
            next_count = timer_count + 16'h0001;
        end
        `TMRCC_MODE_UPDN:
        begin
          if (!count_down)
          begin
            if (timer_count >= compare_latch[0] &&
                timer_count != 16'h0000)
            begin
              next_down = 1'b1;
              next_count = timer_count - 16'h0001;
            end
            else if (timer_count < compare_latch[0])
              next_count = timer_count + 16'h0001;
          end
          else if (timer_count == 16'h0000)
          begin
            next_down = 1'b0;
            next_count = 16'h0001;
          end
          else
          begin
            next_count = timer_count - 16'h0001;
            rollover = (timer_count == 16'h0001);
          end
        end
        default: next_count = timer_count;
      endcase
    end
  end
  // ****************************************
  // Channel events and latch load decisions.
  // ****************************************
  always @*
  begin
    for (k = 0; k < `TMRCC_NCH; k = k + 1)
    begin
      ch_event[k] = capture_mode[k] ? cap_rise[k] :
        (tick && mode != `TMRCC_MODE_STOP &&
         next_count == compare_latch[k]);
      load_now[k] = load_fires(
        latch_load_sel[2*leader_of(k[2:0], grp) +: 2],
        buf_wr[k], zero_evt, l0_evt,
        mode == `TMRCC_MODE_UPDN);
    end
  end
  // ****************************************
  // Read data and error in the setup cycle.
  // ****************************************
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `TMRCC_OFF_CTL: next_rdata = {16'h0000, timer_control[15:3],
        1'b0, timer_control[`TMRCC_IE_BIT], irq_status[0]};
      `TMRCC_OFF_COUNT: next_rdata = {16'h0000, timer_count};
      `TMRCC_OFF_STATUS: next_rdata = {24'h00_0000, irq_status};
      `TMRCC_OFF_MASK: next_rdata = {24'h00_0000, irq_mask};
      `TMRCC_OFF_CHMODE: next_rdata = {25'h000_0000, capture_mode};
      `TMRCC_OFF_LOADSEL: next_rdata = {18'h0_0000, latch_load_sel};
      default:
      begin
        if (paddr >= `TMRCC_OFF_BUF0 && paddr <= `TMRCC_OFF_BUF6 &&
            paddr[1:0] == 2'h0)
          next_rdata = {16'h0000,
            capture_compare_buffer[paddr[4:2]]};
        else
          next_err = 1'b1;
      end
    endcase
  end
  // ****************************************
  // Bus handshake and outputs.
  // ****************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      irq_out <= 1'b0;
      compare_match <= 7'h00;
    end
    else
    begin
      pready <= rd_setup;
      if (rd_setup)
      begin
        prdata <= next_rdata;
        pslverr <= next_err;
      end
      irq_out <= |(irq_status & irq_mask &
        {7'h7f, timer_control[`TMRCC_IE_BIT]});
      compare_match <= ch_event & ~capture_mode;
    end
  end
  // ****************************************
  // Control, counter and interrupt registers.
  // ****************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      timer_control <= `TMRCC_CTL_RST;
      timer_count <= 16'h0000;
      count_down <= 1'b0;
      irq_status <= 8'h00;
      irq_mask <= 8'h00;
      capture_mode <= 7'h00;
      latch_load_sel <= 14'h0000;
    end
    else
    begin
      timer_count <= next_count;
      count_down <= next_down;
      if (wr_access && paddr == `TMRCC_OFF_CTL)
        timer_control <= pwdata[15:0] & `TMRCC_CTL_WMASK;
      if (wr_access && paddr == `TMRCC_OFF_MASK)
        irq_mask <= pwdata[7:0];
      if (wr_access && paddr == `TMRCC_OFF_CHMODE)
        capture_mode <= pwdata[6:0];
      if (wr_access && paddr == `TMRCC_OFF_LOADSEL)
        latch_load_sel <= pwdata[13:0];
      if (wr_access && paddr == `TMRCC_OFF_STATUS)
        irq_status <= (irq_status & ~pwdata[7:0]) | {ch_event, rollover};
      else if (wr_access && paddr == `TMRCC_OFF_CTL)
        irq_status <= {irq_status[7:1] | ch_event,
          pwdata[`TMRCC_IFG_BIT] | rollover};
      else
        irq_status <= irq_status | {ch_event, rollover};
    end
  end
  // ****************************************
  // Capture pin synchronisers.
  // ****************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cap_s1 <= 7'h00;
      cap_s2 <= 7'h00;
      cap_s3 <= 7'h00;
    end
    else
    begin
      cap_s1 <= capture_in;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end
  // ****************************************
  // Buffers and compare latches.
  // ****************************************
  always @(posedge clk)
  begin
    for (i = 0; i < `TMRCC_NCH; i = i + 1)
    begin
      if (sys_rst)
      begin
        capture_compare_buffer[i] <= 16'h0000;
        compare_latch[i] <= 16'h0000;
      end
      else
      begin
        if (capture_mode[i] && cap_rise[i])
          capture_compare_buffer[i] <= timer_count;
        else if (buf_wr[i])
          capture_compare_buffer[i] <= pwdata[15:0];
        if (!capture_mode[i] && load_now[i])
          compare_latch[i] <= buf_wr[i] ? pwdata[15:0] :
            capture_compare_buffer[i];
      end
    end
  end
endmodule // tmrcc_top
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking testbench of the timer control block.
`timescale 1ns/10ps
`default_nettype none
`include "tmrcc_map.vh"
module testbench;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq_out, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, c;
  logic [2:0] pins;
  logic [6:0] capture_in, compare_match;
  logic [15:0] v;
  integer mismatches, num_checks, seed, i, j, n;
  integer hits [0:6];
  tmrcc_top DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_timer_clock(pins[0]), .aux_clock(pins[1]),
    .submain_clock(pins[2]), .capture_in(capture_in),
    .compare_match(compare_match), .irq_out(irq_out));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    for (int k = 0; k < 7; k++)
      if (compare_match[k] === 1'b1)
        hits[k] <= hits[k] + 1;
  // **********************
  // Bus and pin tasks.
  // **********************
  task automatic chk(input string s, input logic [31:0] e, g);
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    while (pready !== 1'b1)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk("wait", 32'h1, n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string s, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task automatic pulse(input logic [2:0] w, input integer m);
    repeat (m)
    begin
      pins <= w;
      repeat (3) @(posedge clk);
      pins <= 3'h0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clk);
    chk("irq_out", {31'h0, e}, {31'h0, irq_out});
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] g, l, s, d, m);
    return {17'h0, g, l, 1'b0, s, d, m, 4'h0};
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches = mismatches + 1;
    complete_run;
  end
  initial
  begin
    seed = 43678;
    mismatches = 0;
    num_checks = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pins = 3'h0;
    capture_in = 7'h00;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 13; i++)
      rdchk("reset", (i < 6) ? 12'(i * 4) : 12'(i * 4 + 8), 32'h0);
    for (i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 16'hffff : 16'($random(seed));
      v = v | 16'h0300;
      wr(`TMRCC_OFF_CTL, {16'h0, v});
      rdchk("ctl", `TMRCC_OFF_CTL, {16'h0, v & 16'hfffb});
    end
    wr(12'h0fc, 32'hffffffff);
    chk("pslverr", 32'h1, {31'h0, err});
    rdchk("unmapped", 12'h0fc, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    rdchk("ctl", `TMRCC_OFF_CTL, {16'h0, v & 16'hfffb});
    for (i = 0; i < 3; i++)
      for (j = 0; j < 4; j++)
      begin
        wr(`TMRCC_OFF_CTL, cfg(0, 0, 2'(i), 2'(j), 2'h2) | 32'h4);
        pulse(3'h1 << i, 16);
        pulse(3'h7 ^ (3'h1 << i), 3);
        rdchk("count", `TMRCC_OFF_COUNT, 32'd16 >> j);
      end
    wr(`TMRCC_OFF_MASK, 32'h1);
    for (i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0fff : 16'h03ff;
      c = cfg(0, 2'(i), 0, 0, 2'h2);
      wr(`TMRCC_OFF_CTL, c);
      wr(`TMRCC_OFF_COUNT, {16'h0, v - 16'h1});
      pulse(3'h1, 2);
      rdchk("count", `TMRCC_OFF_COUNT, 32'h0);
      rdchk("ctl", `TMRCC_OFF_CTL, c | 32'h1);
      irqchk(1'b0);
    end
    wr(`TMRCC_OFF_CTL, c | 32'h3);
    irqchk(1'b1);
    wr(`TMRCC_OFF_STATUS, 32'h1);
    irqchk(1'b0);
    rdchk("ctl", `TMRCC_OFF_CTL, c | 32'h2);
    wr(`TMRCC_OFF_BUF0, 32'h5);
    for (i = 0; i < 3; i++)
    begin
      wr(`TMRCC_OFF_CTL, cfg(0, 0, 0, 0, (i == 2) ? 2'h3 : 2'(i)) | 32'h4);
      pulse(3'h1, 9);
      rdchk("count", `TMRCC_OFF_COUNT, (i == 0) ? 0 : (i == 1) ? 3 : 1);
    end
    rdchk("buffer", `TMRCC_OFF_BUF0, 32'h5);
    wr(`TMRCC_OFF_LOADSEL, 32'h4);
    for (i = 1; i < 3; i++)
    begin
      wr(`TMRCC_OFF_CTL, cfg(2'(i), 2'h2, 0, 0, 2'h2) | 32'h4);
      for (j = 1; j < 4; j++)
        wr(12'(`TMRCC_OFF_BUF0 + j * 4), 32'(j + 1));
      wr(`TMRCC_OFF_COUNT, 32'h3fe);
      pulse(3'h1, 2);
      for (j = 0; j < 7; j++)
        hits[j] = 0;
      pulse(3'h1, 4);
      for (j = 1; j < 4; j++)
        wr(12'(`TMRCC_OFF_BUF0 + j * 4), 32'(j + 4));
      pulse(3'h1, 3);
      chk("match1", 32'h1, hits[1]);
      chk("match2", 32'h1, hits[2]);
      chk("match3", (i == 1) ? 32'h2 : 32'h1, hits[3]);
      rdchk("buffer", `TMRCC_OFF_BUF0 + 12'h4, 32'h5);
    end
    wr(`TMRCC_OFF_LOADSEL, 32'h30);
    wr(`TMRCC_OFF_CTL, cfg(0, 0, 0, 0, 2'h3) | 32'h4);
    wr(`TMRCC_OFF_BUF0 + 12'h8, 32'h1);
    hits[2] = 0;
    pulse(3'h1, 8);
    chk("match2", 32'h1, hits[2]);
    rdchk("count", `TMRCC_OFF_COUNT, 32'h2);
    wr(`TMRCC_OFF_CHMODE, 32'h20);
    wr(`TMRCC_OFF_CTL, 32'h0);
    wr(`TMRCC_OFF_STATUS, 32'hff);
    v = 16'($random(seed));
    wr(`TMRCC_OFF_COUNT, {16'h0, v});
    capture_in <= 7'h20;
    repeat (3) @(posedge clk);
    capture_in <= 7'h00;
    repeat (6) @(posedge clk);
    rdchk("capture", `TMRCC_OFF_BUF0 + 12'h14, {16'h0, v});
    rdchk("status", `TMRCC_OFF_STATUS, 32'h40);
    irqchk(1'b0);
    wr(`TMRCC_OFF_MASK, 32'h40);
    irqchk(1'b1);
    wr(`TMRCC_OFF_STATUS, 32'h40);
    irqchk(1'b0);
    complete_run;
  end
endmodule // testbench
bind tmrcc_top tmrcc_props u_props (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .external_timer_clock(external_timer_clock), .aux_clock(aux_clock),
  .submain_clock(submain_clock), .capture_in(capture_in),
  .compare_match(compare_match), .irq_out(irq_out));
`default_nettype wire

// >>> sim/tmrcc_props.sv
// Port checker of the timer control block.
`timescale 1ns/10ps
`default_nettype none
`include "tmrcc_map.vh"
module tmrcc_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_timer_clock,
  input wire logic aux_clock,
  input wire logic submain_clock,
  input wire logic [6:0] capture_in,
  input wire logic [6:0] compare_match,
  input wire logic irq_out
);
  // ******************************************
  // Shadow of the control and mask registers.
  // ******************************************
  logic [15:0] ctl_sh;
  logic [7:0] mask_sh;
  wire logic setup = psel && !penable;
  wire logic done = psel && penable && pready && pwrite && !pslverr;
  wire logic rd_ctl = setup && !pwrite && paddr == `TMRCC_OFF_CTL;
  wire logic quiet = !ctl_sh[1] && mask_sh[7:1] == 7'h00;
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctl_sh <= 16'h0000;
      mask_sh <= 8'h00;
    end
    else
    begin
      if (done && paddr == `TMRCC_OFF_CTL)
        ctl_sh <= pwdata[15:0] & `TMRCC_CTL_WMASK;
      if (done && paddr == `TMRCC_OFF_MASK)
        mask_sh <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_rdy;
    setup |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_rdy_cause;
    pready |-> $past(setup);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("stray pready");
  property p_unmapped;
    setup && !pwrite && paddr == 12'h0fc |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped");
  property p_ctl_back;
    rd_ctl |=> prdata == {16'h0, $past(ctl_sh[15:1]), prdata[0]};
  endproperty
  a_ctl_back: assert property (p_ctl_back) else $error("ctl readback");
  property p_clr_zero;
    rd_ctl |=> !prdata[2];
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear bit seen");
  property p_irq_gated;
    quiet && $past(quiet) |-> !irq_out;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq ungated");
  property p_match_pulse;
    compare_match != 7'h00 |=> (compare_match & $past(compare_match)) == 7'h00;
  endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("long match");
  property p_no_clk;
    (ctl_sh[9:8] == 2'h3) [*8] |-> compare_match == 7'h00;
  endproperty
  a_no_clk: assert property (p_no_clk) else $error("match unclocked");
  c_match: cover property (compare_match != 7'h00);
  c_irq: cover property (irq_out);
  c_err: cover property (pslverr);
endmodule // tmrcc_props
`default_nettype wire
